// [serial_config_pkg.sv]
// constants and types shared by the serial configuration port
package serial_config_pkg;
  // frame layout
  localparam int FRAME_BITS = 24;
  localparam int ADDR_BITS  = 8;
  localparam int DATA_BITS  = 16;
  localparam logic [4:0] LAST_BIT_COUNT = 5'(FRAME_BITS - 1);
  localparam logic [4:0] ADDR_DONE_COUNT = 5'(ADDR_BITS);
  // register addresses
  localparam logic [7:0] ADDR_RESET_CTRL  = 8'h00;
  localparam logic [7:0] ADDR_POWER       = 8'h01;
  localparam logic [7:0] ADDR_PATTERN     = 8'h02;
  localparam logic [7:0] ADDR_INVERT      = 8'h03;
  localparam logic [7:0] ADDR_CUSTOM      = 8'h05;
  localparam logic [7:0] ADDR_OFFSET_BASE = 8'h0d;
  localparam logic [7:0] ADDR_OFFSET_STEP = 8'h02;
  // reset value of every register
  localparam logic [15:0] REG_RESET = 16'h0000;
  // register 0 fields
  localparam int SW_RESET_BIT = 0;
  localparam int READOUT_BIT  = 1;
  // register 1 fields
  localparam int FULL_PDN_BIT    = 0;
  localparam int OUT_DISABLE_BIT = 1;
  localparam int CH_PDN_LSB      = 2;
  localparam int PARTIAL_POWERDOWN_BIT = 10;
  localparam int DOUBLE_RATE_BIT = 14;
  // register 2 fields
  localparam int LANE_PDN_LSB = 3;
  localparam int AVERAGE_BIT  = 11;
  localparam int LOW_LAT_BIT  = 12;
  localparam int PATTERN_LSB  = 13;
  // register 3 fields
  localparam int INVERT_LSB    = 0;
  localparam int OFFSET_EN_BIT = 8;
  // field widths
  localparam int CODE_BITS   = 14;
  localparam int OFFSET_BITS = 10;
  // pipeline latency in converter clocks
  localparam logic [3:0] LATENCY_DEFAULT = 4'hb;
  localparam logic [3:0] LATENCY_LOW     = 4'h8;
  // readback timing seen by the controller
  localparam int MCLK_PERIOD_NS      = 50;
  localparam int FAST_SCLK_PERIOD_NS = 60;
  localparam int FAST_SCLK_CYCLES =
    (FAST_SCLK_PERIOD_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  // output test patterns
  typedef enum logic [2:0] {
    PAT_NORMAL = 3'h0,
    PAT_SYNC   = 3'h1,
    PAT_DESKEW = 3'h2,
    PAT_CUSTOM = 3'h3,
    PAT_ONES   = 3'h4,
    PAT_TOGGLE = 3'h5,
    PAT_ZEROS  = 3'h6,
    PAT_RAMP   = 3'h7
  } pattern_t;
endpackage

// [serial_config_port.sv]
// serial configuration port with register file and output data formatting
//
// Operation
// - shifting only while select is low
// - input sampled on each rising shift edge
// - every 24th edge commits frame
// - trailing partial frame is dropped
// - frame is address byte then data word
// - readout bit enables register read frames
// - readback changes after falling shift edges
// - readout blocks writes except register 0
// - readback driver off unless readout set
// - reset pin pulse clears all registers
// - software reset bit clears, self-clears
// - power-down keeps register contents
// - register 1 power control fields
// - register 1 bit 14 double rate
// - register 2 output pair power-down
// - register 2 bit 11 channel averaging
// - register 2 bit 12 latency select
// - register 2 test pattern select
// - custom pattern from register 5
// - register 3 per-channel inversion
// - register 3 bit 8 offset enable
// - ten-bit offset subtracted on the first OFFSET_REGS channels only
`timescale 1ns/1ps
module serial_config_port
  import serial_config_pkg::*;
#(
  parameter int CHANNELS    = 8,
  parameter int OFFSET_REGS = 4,
  parameter logic [13:0] SYNC_PATTERN   = 14'h3f80,
  parameter logic [13:0] DESKEW_PATTERN = 14'h2aaa
) (
  // system side
  input  wire logic                                mclk,
  input  wire logic                                rst_b,
  // serial link
  input  wire logic                                sclk,
  input  wire logic                                serial_select_n,
  input  wire logic                                serial_in,
  input  wire logic                                hw_reset,
  output logic                                     serial_readback_out,
  output logic                                     serial_readback_oe_n,
  // converter data
  input  wire logic [CHANNELS-1:0][CODE_BITS-1:0]  adc_code,
  output logic [CHANNELS-1:0][CODE_BITS-1:0]       out_code,
  // power and format controls
  output logic                                     full_powerdown,
  output logic                                     output_disable,
  output logic [CHANNELS-1:0]                      channel_powerdown_mask,
  output logic                                     partial_powerdown,
  output logic                                     double_rate_outputs,
  output logic [CHANNELS-1:0]                      lane_powerdown_mask,
  output logic                                     averaging_enable,
  output logic [3:0]                               pipeline_latency,
  output pattern_t                                 test_pattern,
  output logic                                     offset_subtract_enable,
  output logic [OFFSET_BITS-1:0]                   channel_one_offset
);

  // link side state, one struct per clock edge and reset
  typedef struct packed {
    logic [4:0]  count;
    logic [22:0] shift;
  } frame_t;

  typedef struct packed {
    logic                                   readout;
    logic [15:0]                            power;
    logic [15:0]                            pattern;
    logic [15:0]                            invert;
    logic [CODE_BITS-1:0]                   custom;
    logic [OFFSET_REGS-1:0][OFFSET_BITS-1:0] offset;
    logic                                   toggle;
  } cfg_t;

  typedef struct packed {
    logic [15:0] word;
  } readback_t;

  // system side state
  typedef struct packed {
    logic [2:0]                              tog_sync;
    logic [1:0]                              hwr_sync;
    logic [15:0]                             power;
    logic [15:0]                             pattern;
    logic [15:0]                             invert;
    logic [CODE_BITS-1:0]                    custom;
    logic [OFFSET_REGS-1:0][OFFSET_BITS-1:0] offset;
    logic [CODE_BITS-1:0]                    ramp;
    logic                                    phase;
    logic [CHANNELS-1:0][CODE_BITS-1:0]      code;
  } sys_t;

  frame_t    frame;
  frame_t    next_frame;
  cfg_t      cfg;
  cfg_t      next_cfg;
  readback_t rb;
  readback_t next_rb;
  sys_t      sys;
  sys_t      next_sys;

  logic                               frame_clear;
  logic                               commit;
  logic [7:0]                         waddr;
  logic [15:0]                        wdata;
  logic [CHANNELS-1:0][CODE_BITS-1:0] chan_code;

  function automatic logic [7:0] offset_addr(input int k);
    offset_addr = 8'(ADDR_OFFSET_BASE + 8'(k) * ADDR_OFFSET_STEP);
  endfunction

  // readback value; unmapped addresses and the reset bit read zero
  function automatic logic [15:0] read_word(input cfg_t c,
                                            input logic [7:0] a);
    logic [15:0] w;
    w = REG_RESET;
    case (a)
      ADDR_RESET_CTRL: w[READOUT_BIT] = c.readout;
      ADDR_POWER:      w = c.power;
      ADDR_PATTERN:    w = c.pattern;
      ADDR_INVERT:     w = c.invert;
      ADDR_CUSTOM:     w = {2'h0, c.custom};
      default: begin
        for (int k = 0; k < OFFSET_REGS; k++) begin
          if (a == offset_addr(k)) begin
            w = {6'h00, c.offset[k]};
          end
        end
      end
    endcase
    return w;
  endfunction

  // frame counter and shifter, cleared while select is high
  // select high wipes the count, so spare bits never commit
  assign frame_clear = serial_select_n | hw_reset;

  always_comb begin
    next_frame = frame;
    next_frame.shift = {frame.shift[21:0], serial_in};
    if (frame.count == LAST_BIT_COUNT) begin
      next_frame.count = 5'h00;
    end else begin
      next_frame.count = 5'(frame.count + 5'h01);
    end
  end

  always_ff @(posedge sclk or posedge frame_clear) begin
    if (frame_clear) begin
      frame <= '0;
    end else begin
      frame <= next_frame;
    end
  end

  // the 24th edge: address in the upper byte, data below
  assign commit = (frame.count == LAST_BIT_COUNT);
  assign waddr  = frame.shift[22:15];
  assign wdata  = {frame.shift[14:0], serial_in};

  // register file lives on the shift clock so reads need no crossing
  always_comb begin
    next_cfg = cfg;
    if (commit) begin
      next_cfg.toggle = ~cfg.toggle;
      if (waddr == ADDR_RESET_CTRL) begin
        if (wdata[SW_RESET_BIT]) begin
          next_cfg        = '0;
          next_cfg.toggle = ~cfg.toggle;
        end else begin
          next_cfg.readout = wdata[READOUT_BIT];
        end
      end else if (!cfg.readout) begin
        case (waddr)
          ADDR_POWER:   next_cfg.power   = wdata;
          ADDR_PATTERN: next_cfg.pattern = wdata;
          ADDR_INVERT:  next_cfg.invert  = wdata;
          ADDR_CUSTOM:  next_cfg.custom  = wdata[CODE_BITS-1:0];
          default: begin
            for (int k = 0; k < OFFSET_REGS; k++) begin
              if (waddr == offset_addr(k)) begin
                next_cfg.offset[k] = wdata[OFFSET_BITS-1:0];
              end
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge sclk or posedge hw_reset) begin
    if (hw_reset) begin
      cfg <= '0;
    end else begin
      cfg <= next_cfg;
    end
  end

  // readback shifter on the falling edge, loaded once the address is in
  always_comb begin
    next_rb = rb;
    if (frame.count == ADDR_DONE_COUNT) begin
      next_rb.word = read_word(cfg, frame.shift[7:0]);
    end else begin
      next_rb.word = {rb.word[14:0], 1'b0};
    end
  end

  always_ff @(negedge sclk or posedge frame_clear) begin
    if (frame_clear) begin
      rb <= '0;
    end else begin
      rb <= next_rb;
    end
  end

  assign serial_readback_out  = rb.word[15];
  // shared line: stay off unless readout is enabled
  assign serial_readback_oe_n = ~cfg.readout;

  // per-channel formatting on the system clock
  for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_chan
    localparam int MATE = ch ^ 1;
    logic [CODE_BITS:0]   pair_sum;
    logic [CODE_BITS-1:0] avg;
    logic [CODE_BITS-1:0] off;
    logic [CODE_BITS-1:0] sub;
    logic [CODE_BITS-1:0] inv;
    logic                 dark;

    if (MATE < CHANNELS) begin : g_pair
      assign pair_sum = {1'b0, adc_code[ch]} + {1'b0, adc_code[MATE]};
    end else begin : g_single
      assign pair_sum = {adc_code[ch], 1'b0};
    end

    assign avg = sys.pattern[AVERAGE_BIT] ?
                 pair_sum[CODE_BITS:1] : adc_code[ch];

    if (ch < OFFSET_REGS) begin : g_off
      assign off = {4'h0, sys.offset[ch]};
    end else begin : g_nooff
      assign off = '0;
    end

    assign sub = sys.invert[OFFSET_EN_BIT] ?
                 CODE_BITS'(avg - off) : avg;
    assign inv = sub ^ {CODE_BITS{sys.invert[INVERT_LSB + ch]}};

    assign dark = sys.power[FULL_PDN_BIT] | sys.power[OUT_DISABLE_BIT]
                | sys.power[CH_PDN_LSB + ch]
                | sys.pattern[LANE_PDN_LSB + ch];

    always_comb begin
      if (dark) begin
        chan_code[ch] = '0;
      end else begin
        case (pattern_t'(sys.pattern[PATTERN_LSB +: 3]))
          PAT_NORMAL: chan_code[ch] = inv;
          PAT_SYNC:   chan_code[ch] = SYNC_PATTERN;
          PAT_DESKEW: chan_code[ch] = DESKEW_PATTERN;
          PAT_CUSTOM: chan_code[ch] = sys.custom;
          PAT_ONES:   chan_code[ch] = '1;
          PAT_TOGGLE: chan_code[ch] = {CODE_BITS{sys.phase}};
          PAT_ZEROS:  chan_code[ch] = '0;
          PAT_RAMP:   chan_code[ch] = sys.ramp;
          default:    chan_code[ch] = inv;
        endcase
      end
    end
  end

  // copy of the register file, taken when a commit toggle arrives
  // contents hold still for a whole frame, so a toggle handshake suffices
  always_comb begin
    next_sys          = sys;
    next_sys.tog_sync = {sys.tog_sync[1:0], cfg.toggle};
    next_sys.hwr_sync = {sys.hwr_sync[0], hw_reset};
    next_sys.ramp     = CODE_BITS'(sys.ramp + 14'h0001);
    next_sys.phase    = ~sys.phase;
    next_sys.code     = chan_code;
    if (sys.hwr_sync[1]) begin
      next_sys.power   = REG_RESET;
      next_sys.pattern = REG_RESET;
      next_sys.invert  = REG_RESET;
      next_sys.custom  = '0;
      next_sys.offset  = '0;
    end else if (sys.tog_sync[2] ^ sys.tog_sync[1]) begin
      // power-down bits are only decoded, never clear the copy
      next_sys.power   = cfg.power;
      next_sys.pattern = cfg.pattern;
      next_sys.invert  = cfg.invert;
      next_sys.custom  = cfg.custom;
      next_sys.offset  = cfg.offset;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      sys <= '0;
    end else begin
      sys <= next_sys;
    end
  end

  // decoded controls
  assign out_code               = sys.code;
  assign full_powerdown         = sys.power[FULL_PDN_BIT];
  assign output_disable         = sys.power[OUT_DISABLE_BIT];
  assign channel_powerdown_mask = sys.power[CH_PDN_LSB +: CHANNELS];
  assign partial_powerdown      = sys.power[PARTIAL_POWERDOWN_BIT];
  assign double_rate_outputs    = sys.power[DOUBLE_RATE_BIT];
  assign lane_powerdown_mask    = sys.pattern[LANE_PDN_LSB +: CHANNELS];
  assign averaging_enable       = sys.pattern[AVERAGE_BIT];
  assign pipeline_latency       = sys.pattern[LOW_LAT_BIT] ?
                                  LATENCY_LOW : LATENCY_DEFAULT;
  assign test_pattern           = pattern_t'(sys.pattern[PATTERN_LSB +: 3]);
  assign offset_subtract_enable = sys.invert[OFFSET_EN_BIT];
  assign channel_one_offset     = sys.offset[0];

endmodule

// [serial_config_props.sv]
// assertion checker for the serial configuration port
`timescale 1ns/1ps
module serial_config_props
  import serial_config_pkg::*;
#(
  parameter int CHANNELS = 8
) (
  // clock and resets
  input wire logic                               mclk,
  input wire logic                               rst_b,
  input wire logic                               hw_reset,
  // serial link
  input wire logic                               serial_select_n,
  input wire logic                               serial_readback_oe_n,
  // controls and data
  input wire logic [CHANNELS-1:0][CODE_BITS-1:0] out_code,
  input wire logic                               full_powerdown,
  input wire logic                               output_disable,
  input wire logic [CHANNELS-1:0]                channel_powerdown_mask,
  input wire logic                               partial_powerdown,
  input wire logic                               double_rate_outputs,
  input wire logic [CHANNELS-1:0]                lane_powerdown_mask,
  input wire logic [3:0]                         pipeline_latency,
  input wire pattern_t                           test_pattern
);
  logic [2:0] idle_cnt;
  logic       clean;
  assign clean = !full_powerdown && !output_disable && !partial_powerdown && !double_rate_outputs
                 && channel_powerdown_mask == '0 && lane_powerdown_mask == '0;
  // copies settle some mclk after a commit, so wait before demanding calm
  always_ff @(posedge mclk) begin
    if (!rst_b || !serial_select_n || hw_reset) begin
      idle_cnt <= 3'h0;
    end else if (idle_cnt != 3'h7) begin
      idle_cnt <= idle_cnt + 3'h1;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  a_pin_reset_tristate: assert property (hw_reset |-> serial_readback_oe_n)
    else $error("readback driver on during reset pin");
  a_pin_reset_clears: assert property (hw_reset [*4] |-> !full_powerdown && channel_powerdown_mask == '0
    && test_pattern == PAT_NORMAL && pipeline_latency == LATENCY_DEFAULT) else $error("reset pin left controls set");
  a_idle_oe_steady: assert property (serial_select_n && $past(serial_select_n) && !hw_reset && !$past(hw_reset)
    |-> $stable(serial_readback_oe_n)) else $error("driver enable moved while deselected");
  a_idle_ctrl_steady: assert property (idle_cnt >= 3'h6 |-> $stable({full_powerdown, output_disable,
    channel_powerdown_mask, partial_powerdown, lane_powerdown_mask, pipeline_latency, test_pattern}))
    else $error("controls moved without a complete frame");
  a_ones_pattern: assert property (clean && test_pattern == PAT_ONES |=> out_code[0] == '1)
    else $error("all ones pattern wrong");
  a_zeros_pattern: assert property (clean && test_pattern == PAT_ZEROS |=> out_code[0] == '0)
    else $error("all zeros pattern wrong");
  a_toggle_flips: assert property (clean && $past(clean) && test_pattern == PAT_TOGGLE
    && $past(test_pattern) == PAT_TOGGLE |=> out_code[0] == ~$past(out_code[0])) else $error("toggle did not flip");
  a_ramp_steps: assert property (clean && $past(clean) && test_pattern == PAT_RAMP
    && $past(test_pattern) == PAT_RAMP |=> out_code[0] == 14'($past(out_code[0]) + 14'h1)) else $error("ramp step wrong");
  a_lane_off_zero: assert property (lane_powerdown_mask[CHANNELS-1] |=> out_code[CHANNELS-1] == '0)
    else $error("powered down lane not zero");
  a_chan_off_zero: assert property (channel_powerdown_mask[0] |=> out_code[0] == '0)
    else $error("powered down channel not zero");
  c_toggle: cover property (clean && test_pattern == PAT_TOGGLE);
  c_pin_reset: cover property (hw_reset [*4]);
  c_readout_on: cover property ($fell(serial_readback_oe_n));
endmodule
bind serial_config_port serial_config_props #(.CHANNELS(CHANNELS)) serial_config_props_i (
  .mclk(mclk), .rst_b(rst_b), .hw_reset(hw_reset), .serial_select_n(serial_select_n),
  .serial_readback_oe_n(serial_readback_oe_n), .out_code(out_code), .full_powerdown(full_powerdown),
  .output_disable(output_disable), .channel_powerdown_mask(channel_powerdown_mask),
  .partial_powerdown(partial_powerdown), .double_rate_outputs(double_rate_outputs),
  .lane_powerdown_mask(lane_powerdown_mask), .pipeline_latency(pipeline_latency), .test_pattern(test_pattern)
);

// [serial_controller_model.sv]
// behavioural model of the external controller on the serial link
`timescale 1ns/1ps
module serial_controller_model (
  // link pins
  output logic        sclk,
  output logic        serial_select_n,
  output logic        serial_in,
  input  wire logic   readback,
  // captured read word
  output logic [15:0] rd_word,
  output logic        rd_strobe
);
  initial begin
    sclk = 1'b0;
    serial_select_n = 1'b1;
    serial_in = 1'b0;
    rd_word = 16'h0000;
    rd_strobe = 1'b0;
  end
  task automatic open_frame();
    #3.7;
    serial_select_n = 1'b0;
    #8;
  endtask
  task automatic close_frame();
    #8;
    serial_select_n = 1'b1;
    serial_in = 1'b0;
  endtask
  // n leading bits of a frame; clock idles low outside frames
  task automatic shift(input logic [23:0] f, input int n, input bit capt);
    for (int i = 0; i < n; i++) begin
      serial_in = f[23-i];
      #6 sclk = 1'b1;
      #5;
      // fast clock: take the bit late in the high phase, just before the next fall
      if (i >= 8) rd_word = {rd_word[14:0], readback};
      #1 sclk = 1'b0;
    end
    if (capt && n == 24) begin
      rd_strobe = 1'b1;
      #1 rd_strobe = 1'b0;
    end
  endtask
endmodule

// [serial_config_port_test.sv]
// self-checking testbench for the serial configuration port
`timescale 1ns/1ps
module serial_config_port_test
  import serial_config_pkg::*;
();
  logic                    mclk, rst_b, hw_reset, sclk, serial_select_n, serial_in;
  logic                    serial_readback_out, serial_readback_oe_n, rd_strobe;
  logic [7:0][13:0]        adc_code, out_code;
  logic                    full_powerdown, output_disable, partial_powerdown, double_rate_outputs;
  logic                    averaging_enable, offset_subtract_enable;
  logic [7:0]              channel_powerdown_mask, lane_powerdown_mask;
  logic [3:0]              pipeline_latency;
  pattern_t                test_pattern;
  logic [9:0]              channel_one_offset;
  logic [15:0]             rd_word, r1, r2, r3, cust;
  logic [15:0]             exp_q[$];
  logic [31:0]             seed = 32'hecc8;
  int                      err_count = 0;
  int                      n_checks = 0;
  // no pull-up on the shared readback line
  wire                     readback_line = serial_readback_oe_n ? 1'bz : serial_readback_out;
  serial_config_port serial_config_port_i (
    .mclk(mclk), .rst_b(rst_b), .sclk(sclk), .serial_select_n(serial_select_n), .serial_in(serial_in),
    .hw_reset(hw_reset), .serial_readback_out(serial_readback_out), .serial_readback_oe_n(serial_readback_oe_n),
    .adc_code(adc_code), .out_code(out_code), .full_powerdown(full_powerdown), .output_disable(output_disable),
    .channel_powerdown_mask(channel_powerdown_mask), .partial_powerdown(partial_powerdown),
    .double_rate_outputs(double_rate_outputs), .lane_powerdown_mask(lane_powerdown_mask),
    .averaging_enable(averaging_enable), .pipeline_latency(pipeline_latency), .test_pattern(test_pattern),
    .offset_subtract_enable(offset_subtract_enable), .channel_one_offset(channel_one_offset)
  );
  serial_controller_model serial_controller_model_i (
    .sclk(sclk), .serial_select_n(serial_select_n), .serial_in(serial_in), .readback(readback_line),
    .rd_word(rd_word), .rd_strobe(rd_strobe)
  );
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR time=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks=%0d errors=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // six mclk covers the copy into the mclk domain
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    serial_controller_model_i.open_frame();
    serial_controller_model_i.shift({a, d}, 24, 1'b0);
    serial_controller_model_i.close_frame();
    repeat (6) @(negedge mclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    serial_controller_model_i.open_frame();
    // a read frame to register 0 also writes it, so keep readout set there
    serial_controller_model_i.shift({a, (a == ADDR_RESET_CTRL) ? e : 16'(xs())}, 24, 1'b1);
    serial_controller_model_i.close_frame();
    @(negedge mclk);
  endtask
  always #25 mclk = ~mclk;
  always @(negedge mclk) begin
    for (int k = 0; k < 8; k++) adc_code[k] <= 14'(xs());
  end
  always @(posedge rd_strobe) begin
    if (exp_q.size() == 0) begin
      check(32'h1, 32'h0);
    end else begin
      check(rd_word, exp_q.pop_front());
    end
  end
  initial begin
    #200000;
    err_count++;
    give_verdict();
  end
  initial begin
    mclk = 1'b0;
    rst_b = 1'b0;
    hw_reset = 1'b1;
    adc_code = '0;
    repeat (16) @(negedge mclk);
    rst_b = 1'b1;
    repeat (4) @(negedge mclk);
    hw_reset = 1'b0;
    @(negedge mclk);
    check({serial_readback_oe_n, full_powerdown, test_pattern, pipeline_latency}, {1'b1, 1'b0, PAT_NORMAL, LATENCY_DEFAULT});
    for (int i = 0; i < 3; i++) begin
      r1 = 16'(xs()) & 16'hefff | (i == 2 ? 16'h0401 : 16'h0000);
      r2 = 16'(xs()) & 16'hfff8;
      r3 = 16'(xs()) & 16'hf1ff;
      serial_controller_model_i.open_frame();
      serial_controller_model_i.shift({ADDR_POWER, r1}, 24, 1'b0);
      serial_controller_model_i.shift({ADDR_PATTERN, r2}, 24, 1'b0);
      serial_controller_model_i.shift({ADDR_INVERT, r3}, 24, 1'b0);
      serial_controller_model_i.shift({ADDR_POWER, ~r1}, 23, 1'b0);
      serial_controller_model_i.close_frame();
      repeat (6) @(negedge mclk);
      check({full_powerdown, output_disable, channel_powerdown_mask, partial_powerdown, double_rate_outputs},
            {r1[0], r1[1], r1[9:2], r1[10], r1[14]});
      check({lane_powerdown_mask, averaging_enable, test_pattern}, {r2[10:3], r2[11], r2[15:13]});
      check(pipeline_latency, r2[12] ? LATENCY_LOW : LATENCY_DEFAULT);
      check(offset_subtract_enable, r3[8]);
    end
    // shifting with select high must be ignored
    serial_controller_model_i.shift({ADDR_PATTERN, ~r2}, 24, 1'b0);
    wr(ADDR_RESET_CTRL, 16'h0002);
    check(serial_readback_oe_n, 1'b0);
    wr(ADDR_POWER, ~r1 & 16'hefff);
    rd(ADDR_POWER, r1);
    rd(ADDR_PATTERN, r2);
    rd(ADDR_INVERT, r3);
    rd(ADDR_RESET_CTRL, 16'h0002);
    check(full_powerdown, 1'b1);
    wr(ADDR_RESET_CTRL, 16'h0001);
    check({serial_readback_oe_n, full_powerdown, channel_powerdown_mask, test_pattern, offset_subtract_enable},
          {1'b1, 1'b0, 8'h00, PAT_NORMAL, 1'b0});
    wr(ADDR_RESET_CTRL, 16'h0002);
    rd(ADDR_POWER, 16'h0000);
    rd(ADDR_RESET_CTRL, 16'h0002);
    wr(ADDR_RESET_CTRL, 16'h0000);
    check(serial_readback_oe_n, 1'b1);
    repeat (3) begin
      @(posedge mclk);
      #1;
      for (int k = 0; k < 8; k++) check(out_code[k], adc_code[k]);
    end
    cust = 16'(xs()) & 16'h3fff;
    wr(ADDR_OFFSET_BASE, cust & 16'h03ff);
    check(channel_one_offset, cust[9:0]);
    wr(ADDR_CUSTOM, cust);
    for (int p = 0; p < 8; p++) begin
      wr(ADDR_PATTERN, 16'(p << PATTERN_LSB));
      check(test_pattern, p[2:0]);
      @(posedge mclk);
      #1;
      if (p == 3) check(out_code[5], cust);
      if (p == 4) check(out_code[5], 14'h3fff);
      if (p == 6) check(out_code[5], 14'h0000);
    end
    wr(ADDR_PATTERN, 16'h1000);
    check(pipeline_latency, LATENCY_LOW);
    wr(ADDR_INVERT, 16'h0101);
    @(posedge mclk);
    #1;
    check(out_code[0], 14'(~(adc_code[0] - cust[9:0])));
    wr(ADDR_PATTERN, 16'h1800);
    @(posedge mclk);
    #1;
    check(out_code[3], 14'(({1'b0, adc_code[2]} + {1'b0, adc_code[3]}) >> 1));
    @(negedge mclk);
    hw_reset = 1'b1;
    repeat (5) @(negedge mclk);
    hw_reset = 1'b0;
    @(negedge mclk);
    check({pipeline_latency, test_pattern, serial_readback_oe_n, averaging_enable, offset_subtract_enable},
          {LATENCY_DEFAULT, PAT_NORMAL, 1'b1, 1'b0, 1'b0});
    check(32'(exp_q.size()), 32'h0);
    give_verdict();
  end
endmodule
